// >>> hdl/dsr_debug_unit.sv
// Debug unit end: save/restore sequencer, lock key and power/reset control
`timescale 1ns/10ps
module dsr_debug_unit (
    input wire logic sys_clk,
    input wire logic rstn,
    dsr_if.dev bus,
    input wire logic proc_reset_n,
    input wire logic power_on_reset_n,
    input wire logic power_down_req,
    input wire logic lock_init,
    input wire logic [31:0] debug_status_control_reg_live,
    output logic core_reset_n,
    output logic no_power_down_request,
    output logic os_locked,
    output logic [4:0] seq_pointer
);
    // ------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------
    logic [1:0] prst_sync;
    logic [1:0] porst_sync;
    logic [1:0] pdreq_sync;
    logic [1:0] lock_sync;
    logic [31:0] debug_status_control_reg_s1;
    logic [31:0] debug_status_control_reg_s2;
    logic any_reset;

    // Two-stage synchronisers for all external levels
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prst_sync <= 2'h3;
            porst_sync <= 2'h3;
            pdreq_sync <= 2'h0;
            lock_sync <= 2'h0;
            debug_status_control_reg_s1 <= 32'h0000_0000;
            debug_status_control_reg_s2 <= 32'h0000_0000;
        end else begin
            prst_sync <= {prst_sync[0], proc_reset_n};
            porst_sync <= {porst_sync[0], power_on_reset_n};
            pdreq_sync <= {pdreq_sync[0], power_down_req};
            lock_sync <= {lock_sync[0], lock_init};
            debug_status_control_reg_s1 <= debug_status_control_reg_live;
            debug_status_control_reg_s2 <= debug_status_control_reg_s1;
        end
    end
    assign any_reset = !prst_sync[1] || !porst_sync[1];

    // ------------------------------------------------------------
    // Saved register storage and sequencer
    // ------------------------------------------------------------
    logic [31:0] regs [0:21];
    dsr_pkg::dsr_seq_t state;
    logic [4:0] ptr;
    logic key_wr;
    logic sr_rd;
    logic sr_wr;
    logic [31:0] seq_rdata;
    logic lock_written;

    assign key_wr = bus.wr && bus.addr == dsr_pkg::ADDR_LOCK_KEY
        && bus.wdata == dsr_pkg::LOCK_KEY;
    assign sr_rd = bus.rd && bus.addr == dsr_pkg::ADDR_SAVE_RESTORE;
    assign sr_wr = bus.wr && bus.addr == dsr_pkg::ADDR_SAVE_RESTORE;

    // OS lock: follows strap until first lock write; key sets, other value clears
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            os_locked <= 1'b0;
            lock_written <= 1'b0;
        end else if (bus.wr && bus.addr == dsr_pkg::ADDR_LOCK_KEY) begin
            os_locked <= key_wr;
            lock_written <= 1'b1;
        end else if (state == dsr_pkg::DSR_IDLE && !lock_written) begin
            os_locked <= lock_sync[1];
        end
    end

    // Sequence state and pointer
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= dsr_pkg::DSR_IDLE;
            ptr <= 5'h1F;
        end else if (key_wr) begin
            state <= dsr_pkg::DSR_LEN;
            ptr <= 5'h00;
        end else begin
            case (state)
                dsr_pkg::DSR_IDLE: begin
                    ptr <= 5'h00;
                end
                dsr_pkg::DSR_LEN: begin
                    if (sr_rd) begin
                        state <= dsr_pkg::DSR_RUN;
                    end
                end
                dsr_pkg::DSR_RUN: begin
                    if ((sr_rd || sr_wr) && ptr != dsr_pkg::SEQ_LEN) begin
                        ptr <= ptr + 5'h01;
                    end
                end
                default: begin
                    state <= dsr_pkg::DSR_IDLE;
                end
            endcase
        end
    end
    assign seq_pointer = ptr;

    // Storage for the 22 saved registers; write mask on the status/control entry only
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 22; i++) begin
                regs[i] <= 32'h0000_0000;
            end
        end else if (state == dsr_pkg::DSR_RUN && sr_wr && ptr < dsr_pkg::SEQ_LEN) begin
            if (ptr == dsr_pkg::ENT_DEBUG_STATUS_CONTROL_REG) begin
                // Read-only flags 5:0 stay live; bits 31:6 restored
                regs[ptr] <= (bus.wdata & ~dsr_pkg::DEBUG_STATUS_CONTROL_REG_RO_MASK)
                    | (bus.wdata & dsr_pkg::DEBUG_STATUS_CONTROL_REG_RESTORE_MASK);
            end else begin
                regs[ptr] <= bus.wdata;
            end
        end
    end

    // Read value of the current sequence slot; status flags live
    always_comb begin
        seq_rdata = 32'h0000_0000;
        if (state == dsr_pkg::DSR_LEN) begin
            seq_rdata = {27'h0, dsr_pkg::SEQ_LEN};
        end else if (ptr < dsr_pkg::SEQ_LEN) begin
            if (ptr == dsr_pkg::ENT_DEBUG_STATUS_CONTROL_REG) begin
                seq_rdata = (regs[ptr] & ~dsr_pkg::DEBUG_STATUS_CONTROL_REG_RO_MASK)
                    | (debug_status_control_reg_s2 & dsr_pkg::DEBUG_STATUS_CONTROL_REG_RO_MASK);
            end else begin
                seq_rdata = regs[ptr];
            end
        end
    end

    // ------------------------------------------------------------
    // Power-down and reset control / status
    // ------------------------------------------------------------
    logic [31:0] power_down_reset_control;
    logic sticky_pd;
    logic sticky_rst;
    logic hold_active;
    logic stat_rd;

    assign stat_rd = bus.rd && bus.addr == dsr_pkg::ADDR_PWR_STATUS;

    // Control register: only bits 2 and 0 stored
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            power_down_reset_control <= dsr_pkg::CTRL_RESET;
        end else if (bus.wr && bus.addr == dsr_pkg::ADDR_PWR_CTRL) begin
            power_down_reset_control <= {29'h0, bus.wdata[dsr_pkg::CTRL_HOLD_BIT],
                1'b0, bus.wdata[dsr_pkg::CTRL_NOPD_BIT]};
        end
    end

    // Sticky flags; hardware set wins over read clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sticky_pd <= 1'b1;
            sticky_rst <= 1'b0;
        end else begin
            if (pdreq_sync[1]) begin
                sticky_pd <= 1'b1;
            end else if (stat_rd) begin
                sticky_pd <= 1'b0;
            end
            if (any_reset) begin
                sticky_rst <= 1'b1;
            end else if (stat_rd) begin
                sticky_rst <= 1'b0;
            end
        end
    end

    // Hold latch: armed by a reset while hold bit set, freed on clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            hold_active <= 1'b0;
        end else if (!power_down_reset_control[dsr_pkg::CTRL_HOLD_BIT]) begin
            hold_active <= 1'b0;
        end else if (any_reset) begin
            hold_active <= 1'b1;
        end
    end

    // Only the non-debug core reset is extended
    assign core_reset_n = !(any_reset || hold_active);
    assign no_power_down_request =
        power_down_reset_control[dsr_pkg::CTRL_NOPD_BIT];
    assign bus.core_powered = !pdreq_sync[1];

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bus.rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            case (bus.addr)
                dsr_pkg::ADDR_SAVE_RESTORE: bus.rdata <= seq_rdata;
                dsr_pkg::ADDR_LOCK_KEY: bus.rdata <= {30'h0, os_locked, 1'b1};
                dsr_pkg::ADDR_PWR_CTRL: bus.rdata <= power_down_reset_control;
                dsr_pkg::ADDR_PWR_STATUS: bus.rdata <= {28'h0, sticky_rst, any_reset,
                    sticky_pd, !pdreq_sync[1]};
                dsr_pkg::ADDR_DEBUG_STATUS_CONTROL_REG_VIEW: bus.rdata <= debug_status_control_reg_s2;
                default: bus.rdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> common/dsr_pkg.sv
// Package: constants and types for the debug save/restore and power-reset control block
package dsr_pkg;
    // ------------------------------------------------------------
    // Register indices (word offsets inside the debug port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_SAVE_RESTORE = 4'h0;
    localparam logic [3:0] ADDR_LOCK_KEY = 4'h1;
    localparam logic [3:0] ADDR_PWR_CTRL = 4'h2;
    localparam logic [3:0] ADDR_PWR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_DEBUG_STATUS_CONTROL_REG_VIEW = 4'h4;
    // ------------------------------------------------------------
    // Keys, counts, fields
    // ------------------------------------------------------------
    localparam logic [31:0] LOCK_KEY = 32'hC5ACCE55;
    localparam logic [4:0] SEQ_LEN = 5'h16;
    localparam int CTRL_NOPD_BIT = 0;
    localparam int CTRL_HOLD_BIT = 2;
    localparam int STAT_PD_BIT = 0;
    localparam int STAT_STICKY_PD_BIT = 1;
    localparam int STAT_RESET_BIT = 2;
    localparam int STAT_STICKY_RST_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DEBUG_STATUS_CONTROL_REG_RESTORE_MASK = 32'h6C00_0000;
    localparam logic [31:0] DEBUG_STATUS_CONTROL_REG_RO_MASK = 32'h0000_003F;
    // Sequence entry numbers for special registers
    localparam logic [4:0] ENT_TX = 5'h10;
    localparam logic [4:0] ENT_DEBUG_STATUS_CONTROL_REG = 5'h11;
    localparam logic [4:0] ENT_RX = 5'h12;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DSR_IDLE = 2'b00,
        DSR_LEN = 2'b01,
        DSR_RUN = 2'b11
    } dsr_seq_t;
endpackage

// >>> common/dsr_if.sv
// Interface: debug port between the software-side end and the debug unit
`timescale 1ns/10ps
interface dsr_if;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic core_powered;
    modport host (output addr, output wdata, output wr, output rd,
        input rdata, input core_powered);
    modport dev (input addr, input wdata, input wr, input rd,
        output rdata, output core_powered);
endinterface

// >>> hdl/dsr_os_host.sv
// Software-side end: runs save or restore sequences over the debug port
`timescale 1ns/10ps
module dsr_os_host (
    input wire logic sys_clk,
    input wire logic rstn,
    dsr_if.host bus,
    input wire logic start_save,
    input wire logic start_restore,
    input wire logic [31:0] restore_data,
    output logic restore_data_take,
    output logic [31:0] save_data,
    output logic save_valid,
    output logic busy
);
    // ------------------------------------------------------------
    // Sequence controller
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_KEY = 3'b001,
        H_LEN = 3'b011,
        H_LENW = 3'b010,
        H_XFER = 3'b110,
        H_DONE = 3'b111
    } dsr_host_t;
    dsr_host_t state;
    logic saving;
    logic [4:0] remain;
    logic [4:0] count;

    assign restore_data_take = state == H_XFER && !saving && remain != 5'h00;
    assign busy = state != H_IDLE;

    // Only starts a sequence when core is powered
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= H_IDLE;
            saving <= 1'b0;
            remain <= 5'h00;
            count <= 5'h00;
        end else begin
            case (state)
                H_IDLE: begin
                    if ((start_save || start_restore) && bus.core_powered) begin
                        saving <= start_save;
                        state <= H_KEY;
                    end
                end
                H_KEY: state <= H_LEN;
                H_LEN: state <= H_LENW;
                H_LENW: begin
                    remain <= bus.rdata[4:0];
                    count <= bus.rdata[4:0];
                    state <= H_XFER;
                end
                H_XFER: begin
                    if (remain == 5'h00) begin
                        state <= H_DONE;
                    end else begin
                        remain <= remain - 5'h01;
                    end
                end
                H_DONE: state <= H_IDLE;
                default: state <= H_IDLE;
            endcase
        end
    end

    // Port strobes; one direction per sequence
    always_comb begin
        bus.addr = dsr_pkg::ADDR_SAVE_RESTORE;
        bus.wdata = 32'h0000_0000;
        bus.wr = 1'b0;
        bus.rd = 1'b0;
        if (state == H_KEY) begin
            bus.addr = dsr_pkg::ADDR_LOCK_KEY;
            bus.wdata = dsr_pkg::LOCK_KEY;
            bus.wr = 1'b1;
        end else if (state == H_LEN) begin
            bus.rd = 1'b1;
        end else if (state == H_XFER && remain != 5'h00) begin
            bus.rd = saving;
            bus.wr = !saving;
            bus.wdata = restore_data;
        end
    end

    // Save data captured the cycle after each read
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            save_data <= 32'h0000_0000;
            save_valid <= 1'b0;
        end else begin
            save_valid <= 1'b0;
            if (saving && bus.rd && state == H_XFER) begin
                save_valid <= 1'b1;
            end
            if (saving && state == H_XFER && remain != count) begin
                save_data <= bus.rdata;
            end
        end
    end
endmodule

// >>> verification/dsr_props.sv
// Checker: sequencing properties of the debug port between the two ends
`timescale 1ns/10ps
module dsr_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic core_powered
);
    // ----------------------------------------
    // Access decode and counter
    // ----------------------------------------
    logic [5:0] seq_cnt;
    logic key_wr;
    logic seq_acc;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Key write and sequence port access
    assign key_wr = wr && addr == dsr_pkg::ADDR_LOCK_KEY;
    assign seq_acc = (wr || rd) && addr == dsr_pkg::ADDR_SAVE_RESTORE;
    // Port accesses since the last key write
    always_ff @(posedge sys_clk) begin
        if (!rstn || key_wr) begin
            seq_cnt <= 6'h00;
        end else if (seq_acc) begin
            seq_cnt <= seq_cnt + 6'h01;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_key_value;
        key_wr |-> wdata == 32'hC5ACCE55;
    endproperty
    property p_len_follow;
        key_wr |=> rd && addr == dsr_pkg::ADDR_SAVE_RESTORE;
    endproperty
    property p_no_early_wr;
        key_wr |=> !wr;
    endproperty
    property p_len_value;
        key_wr ##1 (rd && addr == dsr_pkg::ADDR_SAVE_RESTORE) |=> rdata == 32'h0000_0016;
    endproperty
    property p_one_dir;
        (wr && addr == dsr_pkg::ADDR_SAVE_RESTORE) |=> !(rd && addr == dsr_pkg::ADDR_SAVE_RESTORE);
    endproperty
    property p_excl;
        !(wr && rd);
    endproperty
    property p_count;
        seq_acc |-> seq_cnt < 6'h17;
    endproperty
    property p_powered;
        seq_acc |-> core_powered;
    endproperty
    a_key_value: assert property (p_key_value) else $error("bad key value");
    a_len_follow: assert property (p_len_follow) else $error("no length read");
    a_no_early_wr: assert property (p_no_early_wr) else $error("early write");
    a_len_value: assert property (p_len_value) else $error("bad length");
    a_one_dir: assert property (p_one_dir) else $error("mixed access");
    a_excl: assert property (p_excl) else $error("both strobes");
    a_count: assert property (p_count) else $error("too many accesses");
    a_powered: assert property (p_powered) else $error("access unpowered");
    c_save: cover property (key_wr ##1 seq_acc ##1 (rd && addr == 4'h0));
    c_restore: cover property (wr && addr == dsr_pkg::ADDR_SAVE_RESTORE);
    c_key: cover property (key_wr);
endmodule

// >>> verification/test_debug_save_restore_power_reset_ctrl.sv
// Testbench: both ends joined, plus a second debug unit driven by the bench
`timescale 1ns/10ps
module test_debug_save_restore_power_reset_ctrl;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    typedef struct packed {
        logic we;
        logic [3:0] a;
        logic [31:0] d;
        logic npd;
    } dsr_row_t;
    localparam dsr_row_t ROWS [16] = '{
        '{1'h0, 4'h3, 32'h0000_0003, 1'h0}, '{1'h0, 4'h1, 32'h0000_0003, 1'h0},
        '{1'h0, 4'h3, 32'h0000_0001, 1'h0}, '{1'h0, 4'h2, 32'h0000_0000, 1'h0},
        '{1'h1, 4'h2, 32'hFFFF_FFFF, 1'h1}, '{1'h0, 4'h2, 32'h0000_0005, 1'h1},
        '{1'h1, 4'h2, 32'h0000_0000, 1'h0}, '{1'h0, 4'hF, 32'h0000_0000, 1'h0},
        '{1'h1, 4'h1, 32'h0000_0000, 1'h0}, '{1'h0, 4'h1, 32'h0000_0001, 1'h0},
        '{1'h1, 4'h1, 32'hC5AC_CE55, 1'h0}, '{1'h0, 4'h0, 32'h0000_0016, 1'h0},
        '{1'h1, 4'h0, 32'h1111_1111, 1'h0}, '{1'h1, 4'h1, 32'hC5AC_CE55, 1'h0},
        '{1'h0, 4'h0, 32'h0000_0016, 1'h0}, '{1'h0, 4'h0, 32'h1111_1111, 1'h0}};
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic proc_reset_n = 1'h1;
    logic power_on_reset_n = 1'h1;
    logic start_save = 1'h0;
    logic start_restore = 1'h0;
    logic sv_d = 1'h0;
    logic [4:0] rcnt = 5'h00;
    logic [31:0] restore_data;
    logic [31:0] save_data;
    logic restore_data_take, save_valid, busy, core_rst_a, core_rst_b, npd_b;
    logic pd_req = 1'h0;
    logic lock_b;
    logic [4:0] ptr_a;
    logic [31:0] saved [$];
    int err_total = 0;
    int tests_run = 0;
    dsr_if bus_a ();
    dsr_if bus_b ();
    assign restore_data = 32'h6C5A_0000 | {27'h0, rcnt};
    dsr_debug_unit dsr_debug_unit_inst (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_a),
        .proc_reset_n(proc_reset_n), .power_on_reset_n(power_on_reset_n),
        .power_down_req(1'h0), .lock_init(1'h1), .debug_status_control_reg_live(32'h0000_002A),
        .core_reset_n(core_rst_a), .no_power_down_request(), .os_locked(),
        .seq_pointer(ptr_a));
    dsr_debug_unit dsr_debug_unit_inst2 (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_b),
        .proc_reset_n(proc_reset_n), .power_on_reset_n(power_on_reset_n),
        .power_down_req(pd_req), .lock_init(1'h1), .debug_status_control_reg_live(32'h0000_002A),
        .core_reset_n(core_rst_b), .no_power_down_request(npd_b), .os_locked(lock_b),
        .seq_pointer());
    dsr_os_host dsr_os_host_inst (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_a),
        .start_save(start_save), .start_restore(start_restore),
        .restore_data(restore_data), .restore_data_take(restore_data_take),
        .save_data(save_data), .save_valid(save_valid), .busy(busy));
    dsr_props dsr_props_inst (.sys_clk(sys_clk), .rstn(rstn), .addr(bus_a.addr),
        .wdata(bus_a.wdata), .wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata),
        .core_powered(bus_a.core_powered));
    // Clock at 100 MHz
    initial forever #5 sys_clk = ~sys_clk;
    // Saved words follow the valid pulse by one cycle; restore feed advances
    always @(posedge sys_clk) begin
        sv_d <= save_valid;
        if (sv_d === 1'h1) saved.push_back(save_data);
        if (restore_data_take === 1'h1) rcnt <= rcnt + 5'h01;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One strobe cycle on the bench-driven port
    task automatic acc(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_b.wr <= we;
        bus_b.rd <= !we;
        bus_b.addr <= a;
        bus_b.wdata <= d;
        @(posedge sys_clk);
        bus_b.wr <= 1'h0;
        bus_b.rd <= 1'h0;
        #1;
    endtask
    // Starts a host sequence and waits, bounded, until it is idle
    task automatic host_run(input logic save);
        int n = 0;
        @(posedge sys_clk);
        start_save <= save;
        start_restore <= !save;
        @(posedge sys_clk);
        start_save <= 1'h0;
        start_restore <= 1'h0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (busy === 1'h1 && n < 100);
        check("host_done", {31'h0, busy}, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        bus_b.wr = 1'h0;
        bus_b.rd = 1'h0;
        bus_b.addr = 4'h0;
        bus_b.wdata = 32'h0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'h1;
        foreach (ROWS[i]) begin
            acc(ROWS[i].we, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].we) check("reg_read", bus_b.rdata, ROWS[i].d);
            check("no_pd_req", {31'h0, npd_b}, {31'h0, ROWS[i].npd});
        end
        check("lock_after_key", {31'h0, lock_b}, 32'h1);
        // Power controller side: request power-down only while no emulate request
        check("no_pd_idle", {31'h0, npd_b}, 32'h0);
        @(posedge sys_clk);
        pd_req <= 1'h1;
        repeat (4) @(posedge sys_clk);
        acc(1'h0, dsr_pkg::ADDR_PWR_STATUS, 32'h0);
        check("stat_pd", bus_b.rdata, 32'h0000_0002);
        @(posedge sys_clk);
        pd_req <= 1'h0;
        repeat (4) @(posedge sys_clk);
        acc(1'h0, dsr_pkg::ADDR_PWR_STATUS, 32'h0);
        check("stat_pd_kept", bus_b.rdata, 32'h0000_0003);
        acc(1'h0, dsr_pkg::ADDR_PWR_STATUS, 32'h0);
        check("stat_pd_clr", bus_b.rdata, 32'h0000_0001);
        host_run(1'h0);
        host_run(1'h1);
        check("save_count", saved.size(), 32'h16);
        check("ptr_end", {27'h0, ptr_a}, 32'h16);
        foreach (saved[k]) check("save_word", saved[k],
            (k == 17) ? 32'h6C5A_002A : (32'h6C5A_0000 | k));
        for (int k = 0; k < 2; k++) begin
            acc(1'h1, dsr_pkg::ADDR_PWR_CTRL, 32'h0000_0004);
            @(posedge sys_clk);
            proc_reset_n <= (k != 0);
            power_on_reset_n <= (k == 0);
            repeat (3) @(posedge sys_clk);
            proc_reset_n <= 1'h1;
            power_on_reset_n <= 1'h1;
            repeat (8) @(posedge sys_clk);
            #1;
            check("core_held", {31'h0, core_rst_b}, 32'h0);
            check("core_free_a", {31'h0, core_rst_a}, 32'h1);
            acc(1'h0, dsr_pkg::ADDR_PWR_CTRL, 32'h0);
            check("ctrl_in_hold", bus_b.rdata, 32'h0000_0004);
            acc(1'h1, dsr_pkg::ADDR_PWR_CTRL, 32'h0);
            repeat (4) @(posedge sys_clk);
            #1;
            check("core_free", {31'h0, core_rst_b}, 32'h1);
        end
        acc(1'h1, dsr_pkg::ADDR_PWR_CTRL, 32'h0000_0005);
        @(posedge sys_clk);
        rstn <= 1'h0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'h1;
        acc(1'h0, dsr_pkg::ADDR_PWR_CTRL, 32'h0);
        check("ctrl_after_rst", bus_b.rdata, 32'h0);
        check("npd_after_rst", {31'h0, npd_b}, 32'h0);
        tally_and_finish;
    end
    // Cuts a hang short
    initial begin
        #(5000 * 10);
        err_total++;
        tally_and_finish;
    end
endmodule
